// *** core/mdp_top.sv ***
// Purpose: motor drive protection: thermal, overload, stall, phase loss, external trip
// Assumes: AHB-Lite single word transfers, same-clock ramp state and current sample
// Notes: any trip latches output off until software clears it or reset
//
// How it works
// - thermal enable trips output time-inverse above the continuous level, in one minute at the one-minute level
// - one-minute level 50..200 percent, default 150, never below continuous
// - continuous level 50..150 percent, default 100, never above one-minute
// - cooling type 0 shaft fan derates at low speed, 1 separate fan
// - warning level 30..150 percent default 150, warning time 0..30 s default 10
// - warning drives terminal or relay whose function code is 5
// - terminal and relay codes 0..19, defaults 12 and 17
// - enabled overload trip cuts output after level persists for trip time
// - stall field bits: 0 accel, 1 constant speed, 2 decel
// - accel with stall enabled: decelerate when current exceeds stall level
// - constant speed with stall enabled: decelerate above stall level
// - decel with stall enabled: suspend decel while link voltage high
// - stall status drives code 7 outputs even with stall field zero
// - phase select: 0 off, 1 output, 2 input, 3 both
// - output phase protection trips on any lost motor phase
// - input protection trips on lost supply phase, else on capacitor wear
// - eight inputs take codes 0..25, any may be external trip
// - code 18 input closed gives fault and output off
// - code 19 input open gives fault and output off
`timescale 1ns/1ps
`default_nettype none
module mdp_top
  import mdp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mdp_ahb_req_s ahb_req,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [8:0] motor_current_pct,
  input wire logic accel_phase,
  input wire logic const_phase,
  input wire logic decel_phase,
  input wire logic low_speed,
  input wire logic run_active,
  input wire mdp_pins_s pins,
  output logic output_off,
  output logic fault_indicate,
  output logic stall_decel_request,
  output logic decel_hold,
  output logic overload_warning_flag,
  output logic open_collector_output,
  output logic changeover_relay_output
);
  typedef struct packed {
    mdp_cfg_s cfg;
    logic [FAULT_W-1:0] fault;
    logic [15:0] s1, s2, s3, pin;
    logic [16:0] tick_cnt;
    logic [15:0] warn_ms, trip_ms;
    logic [31:0] heat;
    logic warn, stall_req, hold, mo, rly;
    logic wr_pend;
    logic [7:0] wr_addr, rd_addr;
  } mdp_state_s;

  mdp_state_s st_reg, st_next;

  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] ms_of(input logic [5:0] s);
    return 16'(16'(s) * 16'(MS_PER_S));
  endfunction

  function automatic logic [15:0] hold_cnt(input logic over, input logic tick,
                                           input logic [15:0] c);
    if (!over) return 16'h0000;
    if (tick && c != 16'hFFFF) return 16'(c + 16'h0001);
    return c;
  endfunction

  function automatic logic fn_out(input logic [4:0] code, input logic warn,
                                  input logic stall, input logic run, input logic flt);
    case (code)
      FN_OVERLOAD: return warn;
      FN_STALL: return stall;
      FN_RUNNING: return run;
      FN_FAULT: return flt;
      default: return 1'b0;
    endcase
  endfunction

  logic tick, acc_ok, write_now, clear_req, stall_over, over_warn, over_trip;
  logic in_lost, out_lost, ext_trip, therm_hot, stall_status;
  logic [7:0] cont_eff;
  logic [8:0] heat_up, heat_dn;
  logic [31:0] heat_lim, wd;
  logic [FAULT_W-1:0] fault_set;

  assign tick = (st_reg.tick_cnt == 17'(TICK_CYCLES - 1));
  assign acc_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign write_now = st_reg.wr_pend;
  assign wd = ahb_req.hwdata;
  assign clear_req = write_now && st_reg.wr_addr == A_CTRL && wd[CTRL_CLEAR_BIT];

  // shaft fan loses cooling at low speed, so a quarter of the continuous rating goes
  assign cont_eff = (!st_reg.cfg.motor_cooling_type && low_speed) ?
    8'(st_reg.cfg.thermal_continuous_level - (st_reg.cfg.thermal_continuous_level >> 2)) :
    st_reg.cfg.thermal_continuous_level;
  assign heat_up = 9'(motor_current_pct - {1'b0, cont_eff});
  assign heat_dn = 9'({1'b0, cont_eff} - motor_current_pct);
  assign heat_lim = 32'(st_reg.cfg.thermal_one_minute_level - st_reg.cfg.thermal_continuous_level)
                    * 32'(THERM_WINDOW_MS);
  // an empty heat store never trips, so equal levels do not cut a cold motor
  assign therm_hot = st_reg.cfg.thermal_protect_enable && st_reg.heat >= heat_lim &&
                     st_reg.heat != 32'h00000000;

  assign over_warn = motor_current_pct > {1'b0, st_reg.cfg.overload_warn_level};
  assign over_trip = motor_current_pct > {1'b0, st_reg.cfg.overload_trip_level};
  assign stall_over = motor_current_pct > {1'b0, st_reg.cfg.stall_current_level};
  // status ignores the enable field so it can be watched with prevention off
  assign stall_status = (stall_over && (accel_phase || const_phase)) ||
                        (decel_phase && st_reg.pin[14]);

  assign in_lost = |st_reg.pin[10:8];
  assign out_lost = |st_reg.pin[13:11];

  always_comb begin
    ext_trip = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (st_reg.cfg.input_function[i] == IN_EXT_NO && st_reg.pin[i]) begin
        ext_trip = 1'b1;
      end
      if (st_reg.cfg.input_function[i] == IN_EXT_NC && !st_reg.pin[i]) begin
        ext_trip = 1'b1;
      end
    end
  end

  always_comb begin
    fault_set = '0;
    fault_set[F_THERM] = therm_hot;
    fault_set[F_OLTRIP] = st_reg.cfg.overload_trip_enable && over_trip &&
                          st_reg.trip_ms >= ms_of(st_reg.cfg.overload_trip_time);
    fault_set[F_OUTPH] = st_reg.cfg.phase_loss_select[0] && out_lost;
    fault_set[F_INPH] = st_reg.cfg.phase_loss_select[1] && in_lost;
    fault_set[F_CAP] = st_reg.cfg.phase_loss_select[1] && !in_lost && st_reg.pin[15];
    fault_set[F_EXT] = ext_trip;
  end

  always_comb begin
    st_next = st_reg;
    // pins: three stages, a change counts once the last two agree
    st_next.s1 = {pins.cap_replace, pins.dclink_high, pins.out_phase_lost,
                  pins.in_phase_lost, pins.contact_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < 16; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.pin[i] = st_reg.s3[i];
      end
    end
    st_next.tick_cnt = tick ? 17'h00000 : 17'(st_reg.tick_cnt + 17'h00001);

    if (!st_reg.cfg.thermal_protect_enable) begin
      st_next.heat = 32'h00000000;
    end else if (tick && motor_current_pct > {1'b0, cont_eff}) begin
      st_next.heat = (st_reg.heat >= heat_lim) ? st_reg.heat : st_reg.heat + 32'(heat_up);
    end else if (tick) begin
      st_next.heat = (st_reg.heat > 32'(heat_dn)) ? st_reg.heat - 32'(heat_dn) : 32'h00000000;
    end

    st_next.warn_ms = hold_cnt(over_warn, tick, st_reg.warn_ms);
    st_next.trip_ms = hold_cnt(over_trip, tick, st_reg.trip_ms);
    // released at once when the current drops back under the level
    st_next.warn = over_warn &&
                   st_reg.warn_ms >= ms_of({1'b0, st_reg.cfg.overload_warn_time});

    st_next.stall_req = stall_over &&
      ((accel_phase && st_reg.cfg.stall_phase_enable_bits[0]) ||
       (const_phase && st_reg.cfg.stall_phase_enable_bits[1]));
    st_next.hold = decel_phase && st_reg.cfg.stall_phase_enable_bits[2] &&
                   st_reg.pin[14];

    // a new trip in the clearing cycle survives the clear
    st_next.fault = (st_reg.fault & {FAULT_W{!clear_req}}) | fault_set;

    st_next.mo = fn_out(st_reg.cfg.output_terminal_function, st_reg.warn, stall_status,
                        run_active && !(|st_reg.fault), |st_reg.fault);
    st_next.rly = fn_out(st_reg.cfg.output_relay_function, st_reg.warn, stall_status,
                         run_active && !(|st_reg.fault), |st_reg.fault);

    st_next.wr_pend = acc_ok && ahb_req.hwrite;
    if (acc_ok) begin
      st_next.wr_addr = ahb_req.haddr[7:0];
      st_next.rd_addr = ahb_req.haddr[7:0];
    end
    if (write_now) begin
      case (st_reg.wr_addr)
        A_CTRL: begin
          st_next.cfg.thermal_protect_enable = wd[0];
          st_next.cfg.motor_cooling_type = wd[1];
          st_next.cfg.overload_trip_enable = wd[2];
          st_next.cfg.stall_phase_enable_bits = wd[6:4];
          st_next.cfg.phase_loss_select = wd[9:8];
        end
        A_THERM: begin
          // out-of-range or crossed levels are dropped whole
          if (in_rng(wd[7:0], TH1M_MIN, TH1M_MAX) && in_rng(wd[15:8], TH1M_MIN, THC_MAX) &&
              wd[15:8] <= wd[7:0]) begin
            st_next.cfg.thermal_one_minute_level = wd[7:0];
            st_next.cfg.thermal_continuous_level = wd[15:8];
          end
        end
        A_WARN: begin
          if (in_rng(wd[7:0], LVL_MIN, WARN_LVL_MAX) && wd[20:16] <= WARN_T_MAX) begin
            st_next.cfg.overload_warn_level = wd[7:0];
            st_next.cfg.overload_warn_time = wd[20:16];
          end
        end
        A_TRIP: begin
          if (in_rng(wd[7:0], LVL_MIN, LVL_MAX) && wd[21:16] <= TRIP_T_MAX) begin
            st_next.cfg.overload_trip_level = wd[7:0];
            st_next.cfg.overload_trip_time = wd[21:16];
          end
        end
        A_STALL: begin
          if (in_rng(wd[7:0], LVL_MIN, LVL_MAX)) begin
            st_next.cfg.stall_current_level = wd[7:0];
          end
        end
        A_OUTFN: begin
          if (wd[4:0] <= OUT_FN_MAX && wd[12:8] <= OUT_FN_MAX) begin
            st_next.cfg.output_terminal_function = wd[4:0];
            st_next.cfg.output_relay_function = wd[12:8];
          end
        end
        A_INFN_LO, A_INFN_HI: begin
          for (int i = 0; i < 4; i++) begin
            if (wd[8*i +: 5] <= IN_FN_MAX) begin
              st_next.cfg.input_function[i + (st_reg.wr_addr == A_INFN_HI ? 4 : 0)] =
                wd[8*i +: 5];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.cfg.overload_trip_enable <= 1'b1;
      st_reg.cfg.thermal_one_minute_level <= TH1M_RST;
      st_reg.cfg.thermal_continuous_level <= THC_RST;
      st_reg.cfg.overload_warn_level <= WARN_LVL_RST;
      st_reg.cfg.overload_warn_time <= WARN_T_RST;
      st_reg.cfg.overload_trip_level <= TRIP_LVL_RST;
      st_reg.cfg.overload_trip_time <= TRIP_T_RST;
      st_reg.cfg.stall_current_level <= STALL_LVL_RST;
      st_reg.cfg.output_terminal_function <= MO_FN_RST;
      st_reg.cfg.output_relay_function <= RLY_FN_RST;
      st_reg.cfg.input_function <= IN_FN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // read mux over flops and the unregistered stall status; zero-wait slave, unmapped reads give zero
  always_comb begin
    hrdata = 32'h00000000;
    case (st_reg.rd_addr)
      A_CTRL: hrdata = {22'h000000, st_reg.cfg.phase_loss_select, 1'b0,
                        st_reg.cfg.stall_phase_enable_bits, 1'b0,
                        st_reg.cfg.overload_trip_enable, st_reg.cfg.motor_cooling_type,
                        st_reg.cfg.thermal_protect_enable};
      A_THERM: hrdata = {16'h0000, st_reg.cfg.thermal_continuous_level,
                         st_reg.cfg.thermal_one_minute_level};
      A_WARN: hrdata = {11'h000, st_reg.cfg.overload_warn_time, 8'h00,
                        st_reg.cfg.overload_warn_level};
      A_TRIP: hrdata = {10'h000, st_reg.cfg.overload_trip_time, 8'h00,
                        st_reg.cfg.overload_trip_level};
      A_STALL: hrdata = {24'h000000, st_reg.cfg.stall_current_level};
      A_OUTFN: hrdata = {19'h00000, st_reg.cfg.output_relay_function, 3'h0,
                         st_reg.cfg.output_terminal_function};
      A_INFN_LO, A_INFN_HI: begin
        for (int i = 0; i < 4; i++) begin
          hrdata[8*i +: 5] = st_reg.cfg.input_function[i +
                                     (st_reg.rd_addr == A_INFN_HI ? 4 : 0)];
        end
      end
      A_STATUS: hrdata = {8'h00, st_reg.pin[7:0], 3'h0, st_reg.rly, st_reg.mo,
                          |st_reg.fault, stall_status, st_reg.warn, 2'h0, st_reg.fault};
      default: hrdata = 32'h00000000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign output_off = |st_reg.fault;
  assign fault_indicate = |st_reg.fault;
  assign stall_decel_request = st_reg.stall_req;
  assign decel_hold = st_reg.hold;
  assign overload_warning_flag = st_reg.warn;
  assign open_collector_output = st_reg.mo;
  assign changeover_relay_output = st_reg.rly;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_therm_off_latch: assert property (
    therm_hot |=> output_off && st_reg.fault[F_THERM])
    else $error("thermal excess did not turn output off");
  a_therm_order: assert property (
    st_reg.cfg.thermal_continuous_level <= st_reg.cfg.thermal_one_minute_level &&
    st_reg.cfg.thermal_one_minute_level >= TH1M_MIN)
    else $error("one-minute level below continuous or range");
  a_therm_cont_rng: assert property (
    st_reg.cfg.thermal_continuous_level inside {[TH1M_MIN:THC_MAX]})
    else $error("continuous level out of range");
  a_warn_cfg_rng: assert property (
    st_reg.cfg.overload_warn_time <= WARN_T_MAX &&
    st_reg.cfg.overload_warn_level inside {[LVL_MIN:WARN_LVL_MAX]})
    else $error("warning settings out of range");
  a_warn_needs_over: assert property (
    !over_warn |=> !overload_warning_flag)
    else $error("warning held with current below level");
  a_mo_follows_warn: assert property (
    st_reg.cfg.output_terminal_function == FN_OVERLOAD ##1
    st_reg.cfg.output_terminal_function == FN_OVERLOAD |->
    open_collector_output == $past(overload_warning_flag))
    else $error("terminal code 5 does not follow warning");
  a_out_fn_rng: assert property (
    st_reg.cfg.output_terminal_function <= OUT_FN_MAX &&
    st_reg.cfg.output_relay_function <= OUT_FN_MAX)
    else $error("output function code out of range");
  a_trip_needs_en: assert property (
    $rose(st_reg.fault[F_OLTRIP]) |-> $past(st_reg.cfg.overload_trip_enable && over_trip))
    else $error("overload trip without enable or current");
  a_stall_accel: assert property (
    accel_phase && st_reg.cfg.stall_phase_enable_bits[0] && stall_over |=>
    stall_decel_request)
    else $error("accel stall did not request deceleration");
  a_decel_hold: assert property (
    decel_hold |-> $past(decel_phase && st_reg.cfg.stall_phase_enable_bits[2]))
    else $error("decel held outside enabled deceleration");
  a_ext_no_trip: assert property (
    st_reg.cfg.input_function[0] == IN_EXT_NO && st_reg.pin[0] |=> output_off [*2])
    else $error("closed normally-open trip did not cut output");
  a_fault_latch: assert property (
    output_off && !clear_req |=> output_off)
    else $error("trip released without clear");
endmodule
`default_nettype wire

// *** core/mdp_pkg.sv ***
// Purpose: shared constants and types of the motor drive protection block
// Assumes: 100 MHz system clock, currents in percent of motor rated current
// Notes: register map, field layout, reset values and timing counts live here
package mdp_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned THERM_WINDOW_MS = 60000;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THERM = 8'h04;
  localparam logic [7:0] A_WARN = 8'h08;
  localparam logic [7:0] A_TRIP = 8'h0C;
  localparam logic [7:0] A_STALL = 8'h10;
  localparam logic [7:0] A_OUTFN = 8'h14;
  localparam logic [7:0] A_INFN_LO = 8'h18;
  localparam logic [7:0] A_INFN_HI = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam int unsigned CTRL_CLEAR_BIT = 31;

  localparam logic [7:0] TH1M_MIN = 8'h32;
  localparam logic [7:0] TH1M_MAX = 8'hC8;
  localparam logic [7:0] THC_MAX = 8'h96;
  localparam logic [7:0] LVL_MIN = 8'h1E;
  localparam logic [7:0] LVL_MAX = 8'hC8;
  localparam logic [7:0] WARN_LVL_MAX = 8'h96;
  localparam logic [4:0] WARN_T_MAX = 5'h1E;
  localparam logic [5:0] TRIP_T_MAX = 6'h3C;
  localparam logic [4:0] OUT_FN_MAX = 5'h13;
  localparam logic [4:0] IN_FN_MAX = 5'h19;

  localparam logic [7:0] TH1M_RST = 8'h96;
  localparam logic [7:0] THC_RST = 8'h64;
  localparam logic [7:0] WARN_LVL_RST = 8'h96;
  localparam logic [4:0] WARN_T_RST = 5'h0A;
  localparam logic [7:0] TRIP_LVL_RST = 8'hB4;
  localparam logic [5:0] TRIP_T_RST = 6'h3C;
  localparam logic [7:0] STALL_LVL_RST = 8'h96;
  localparam logic [4:0] MO_FN_RST = 5'h0C;
  localparam logic [4:0] RLY_FN_RST = 5'h11;
  localparam logic [39:0] IN_FN_RST = 40'h3980000000;

  localparam logic [4:0] FN_OVERLOAD = 5'h05;
  localparam logic [4:0] FN_STALL = 5'h07;
  localparam logic [4:0] FN_RUNNING = 5'h0C;
  localparam logic [4:0] FN_FAULT = 5'h11;
  localparam logic [4:0] IN_EXT_NO = 5'h12;
  localparam logic [4:0] IN_EXT_NC = 5'h13;

  localparam int unsigned F_THERM = 0;
  localparam int unsigned F_OLTRIP = 1;
  localparam int unsigned F_OUTPH = 2;
  localparam int unsigned F_INPH = 3;
  localparam int unsigned F_CAP = 4;
  localparam int unsigned F_EXT = 5;
  localparam int unsigned FAULT_W = 6;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } mdp_ahb_req_s;

  typedef struct packed {
    logic cap_replace;
    logic dclink_high;
    logic [2:0] out_phase_lost;
    logic [2:0] in_phase_lost;
    logic [7:0] contact_in;
  } mdp_pins_s;

  typedef struct packed {
    logic thermal_protect_enable;
    logic motor_cooling_type;
    logic overload_trip_enable;
    logic [2:0] stall_phase_enable_bits;
    logic [1:0] phase_loss_select;
    logic [7:0] thermal_one_minute_level;
    logic [7:0] thermal_continuous_level;
    logic [7:0] overload_warn_level;
    logic [4:0] overload_warn_time;
    logic [7:0] overload_trip_level;
    logic [5:0] overload_trip_time;
    logic [7:0] stall_current_level;
    logic [4:0] output_terminal_function;
    logic [4:0] output_relay_function;
    logic [7:0][4:0] input_function;
  } mdp_cfg_s;
endpackage

// *** verif/mdp_motor_model.sv ***
// Purpose: far side of the protection block: motor current, ramp state, phase and contact pins
// Assumes: the bench states wanted values, the model launches them after each rising edge
// Notes: registered, so every change reaches the block off its sampling edge
`timescale 1ns/1ps
`default_nettype none
module mdp_motor_model
  import mdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [8:0] cur_set,
  input wire logic [1:0] ramp_set,
  input wire logic slow_set,
  input wire mdp_pins_s pins_set,
  output logic [8:0] motor_current_pct,
  output logic accel_phase,
  output logic const_phase,
  output logic decel_phase,
  output logic low_speed,
  output logic run_active,
  output mdp_pins_s pins
);
  // ramp_set: 0 stopped, 1 accelerating, 2 constant speed, 3 decelerating
  always_ff @(posedge clk_sys) begin
    motor_current_pct <= cur_set;
    accel_phase <= (ramp_set == 2'h1);
    const_phase <= (ramp_set == 2'h2);
    decel_phase <= (ramp_set == 2'h3);
    low_speed <= slow_set;
    run_active <= (ramp_set != 2'h0);
    pins <= pins_set;
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: self-checking bench of the protection block over its register bus
// Assumes: millisecond tick shortened to 10 cycles, so one second is 10000 cycles
// Notes: contacts pass a synchroniser, so pin effects are awaited a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb
  import mdp_pkg::*;
;
  logic clk_sys;
  logic reset_n;
  mdp_ahb_req_s req;
  mdp_ahb_req_s bus;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [8:0] cur;
  logic [1:0] ramp;
  logic slow;
  mdp_pins_s pset;
  logic [8:0] motor_current_pct;
  logic accel_phase, const_phase, decel_phase, low_speed, run_active;
  mdp_pins_s pins;
  logic output_off, fault_indicate, stall_decel_request, decel_hold;
  logic overload_warning_flag, open_collector_output, changeover_relay_output;
  int miscompares = 0;
  int checks_done = 0;

  always_comb begin
    bus = req;
    bus.hready = hreadyout;
  end

  mdp_motor_model mdp_motor_model_i (.clk_sys(clk_sys), .cur_set(cur), .ramp_set(ramp),
    .slow_set(slow), .pins_set(pset), .motor_current_pct(motor_current_pct),
    .accel_phase(accel_phase), .const_phase(const_phase), .decel_phase(decel_phase),
    .low_speed(low_speed), .run_active(run_active), .pins(pins));

  mdp_top #(.TICK_CYCLES(10)) mdp_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .ahb_req(bus),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .motor_current_pct(motor_current_pct), .accel_phase(accel_phase),
    .const_phase(const_phase), .decel_phase(decel_phase), .low_speed(low_speed),
    .run_active(run_active), .pins(pins), .output_off(output_off),
    .fault_indicate(fault_indicate), .stall_decel_request(stall_decel_request),
    .decel_hold(decel_hold), .overload_warning_flag(overload_warning_flag),
    .open_collector_output(open_collector_output),
    .changeover_relay_output(changeover_relay_output));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr <= {24'h0, a};
    req.hwrite <= w;
    req.hsize <= 3'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
    chkb("hresp", 1'b0, hresp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk($sformatf("register %h", a), e, q);
  endtask

  // a clear write only works once the cause has gone, since set wins over clear
  task automatic clr(input logic [31:0] c);
    wr(A_CTRL, c | 32'h8000_0000);
    @(posedge clk_sys);
    chkb("output_off after clear", 1'b0, output_off);
  endtask

  task automatic pin_trip(input string nm, input logic e, input logic [31:0] c);
    repeat (8) @(posedge clk_sys);
    chkb(nm, e, output_off);
    pset.in_phase_lost <= 3'h0;
    pset.out_phase_lost <= 3'h0;
    pset.cap_replace <= 1'b0;
    repeat (8) @(posedge clk_sys);
    clr(c);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    miscompares++;
    print_verdict;
  end

  initial begin
    req = '0;
    cur = 9'h000;
    ramp = 2'h0;
    slow = 1'b0;
    pset = '0;
    pset.contact_in = 8'h02;
    reset_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(A_CTRL, 32'h0000_0004);
    rd(A_THERM, 32'h0000_6496);
    rd(A_WARN, 32'h000A_0096);
    rd(A_TRIP, 32'h003C_00B4);
    rd(A_STALL, 32'h0000_0096);
    rd(A_OUTFN, 32'h0000_110C);
    rd(A_INFN_HI, 32'h0706_0000);
    rd(8'h24, 32'h0000_0000);
    wr(A_THERM, 32'h0000_9680);
    rd(A_THERM, 32'h0000_6496);
    wr(A_THERM, 32'h0000_32C9);
    rd(A_THERM, 32'h0000_6496);
    wr(A_THERM, 32'h0000_3232);
    rd(A_THERM, 32'h0000_3232);
    wr(A_OUTFN, 32'h0000_1314);
    rd(A_OUTFN, 32'h0000_110C);
    wr(A_INFN_LO, 32'h1A1A_1312);
    rd(A_INFN_LO, 32'h0000_1312);
    // normally open contact on input 0 closes
    pset.contact_in <= 8'h03;
    repeat (10) if (output_off !== 1'b1) @(posedge clk_sys);
    chkb("output_off", 1'b1, output_off);
    pset.contact_in <= 8'h02;
    repeat (8) @(posedge clk_sys);
    rd(A_STATUS, 32'h0002_1420);
    chkb("fault_indicate", 1'b1, fault_indicate);
    clr(32'h4);
    // normally closed contact on input 1 opens
    pset.contact_in <= 8'h00;
    repeat (10) if (output_off !== 1'b1) @(posedge clk_sys);
    chkb("fault_indicate", 1'b1, fault_indicate);
    pset.contact_in <= 8'h02;
    repeat (8) @(posedge clk_sys);
    clr(32'h4);
    wr(A_OUTFN, 32'h0000_0705);
    wr(A_WARN, 32'h0001_0064);
    cur <= 9'd120;
    ramp <= 2'h2;
    repeat (9000) @(posedge clk_sys);
    chkb("warning early", 1'b0, overload_warning_flag);
    repeat (3000) if (overload_warning_flag !== 1'b1) @(posedge clk_sys);
    chkb("warning", 1'b1, overload_warning_flag);
    repeat (2) @(posedge clk_sys);
    chkb("terminal", 1'b1, open_collector_output);
    cur <= 9'd90;
    repeat (4) @(posedge clk_sys);
    chkb("warning release", 1'b0, overload_warning_flag);
    wr(A_STALL, 32'h0000_0064);
    cur <= 9'd120;
    repeat (4) @(posedge clk_sys);
    chkb("relay stall", 1'b1, changeover_relay_output);
    chkb("stall request off", 1'b0, stall_decel_request);
    wr(A_CTRL, 32'h0000_0024);
    repeat (3) @(posedge clk_sys);
    chkb("stall constant", 1'b1, stall_decel_request);
    ramp <= 2'h1;
    repeat (3) @(posedge clk_sys);
    chkb("stall accel bit off", 1'b0, stall_decel_request);
    wr(A_CTRL, 32'h0000_0014);
    repeat (3) @(posedge clk_sys);
    chkb("stall accel", 1'b1, stall_decel_request);
    ramp <= 2'h3;
    pset.dclink_high <= 1'b1;
    wr(A_CTRL, 32'h0000_0044);
    repeat (5) @(posedge clk_sys);
    chkb("decel hold", 1'b1, decel_hold);
    pset.dclink_high <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chkb("decel release", 1'b0, decel_hold);
    // overload trip at level 150, time 0, first disabled
    wr(A_TRIP, 32'h0000_0096);
    wr(A_CTRL, 32'h0000_0000);
    cur <= 9'd160;
    repeat (6) @(posedge clk_sys);
    chkb("trip disabled", 1'b0, output_off);
    wr(A_CTRL, 32'h0000_0004);
    repeat (4) @(posedge clk_sys);
    chkb("overload trip", 1'b1, output_off);
    cur <= 9'd0;
    ramp <= 2'h0;
    repeat (3) @(posedge clk_sys);
    clr(32'h4);
    for (int s = 0; s < 4; s++) begin
      wr(A_CTRL, 32'h4 | (32'(s) << 8));
      pset.out_phase_lost <= 3'h2;
      pin_trip("output phase", s[0], 32'h4 | (32'(s) << 8));
      pset.in_phase_lost <= 3'h4;
      pin_trip("input phase", s[1], 32'h4 | (32'(s) << 8));
      pset.cap_replace <= 1'b1;
      pin_trip("capacitor", s[1], 32'h4 | (32'(s) << 8));
    end
    // thermal: 51/50 percent, 200 percent current heats 150 per ms, trips after 400 ms
    wr(A_CTRL, 32'h0000_0003);
    wr(A_THERM, 32'h0000_3233);
    cur <= 9'd200;
    repeat (3500) @(posedge clk_sys);
    chkb("thermal early", 1'b0, output_off);
    repeat (1500) if (output_off !== 1'b1) @(posedge clk_sys);
    chkb("thermal trip", 1'b1, output_off);
    print_verdict;
  end
endmodule
`default_nettype wire
